// File: i2c_status_and_data_port.sv
// two-wire bus byte engine with status flags and byte data port
//
// Contract
// - transfer complete low while byte moves, set at ninth clock fall
// - transfer complete meaningful only around a transfer of this module
// - addressed flag set on own address or enabled general call
// - any control write clears the addressed flag
// - busy set on start, cleared on stop
// - arbitration lost when driven high samples low in transmit or ack
// - arbitration lost on busy start, slave repeat start, unrequested stop
// - arbitration flag clears only by writing one or by clearing the enable bit
// - other status bits are read-only
// - status bit three reads zero
// - slave direction holds received read/write bit after address match
// - interrupt flag set on arbitration loss, byte complete, addressed
// - interrupt request while flag set and enable bit one
// - interrupt flag clears only by writing one or by clearing the enable bit
// - received ack flag captures data line at ninth clock
// - master transmit data write starts byte, msb first
// - master receive data read starts next byte reception
// - slave data accesses start transfers only after address match
// - transfer starts only when transmit select matches direction
// - data read returns last received byte, never transmitted ones
// - interrupt enable gates request without clearing pending flag
// - general call enable decides general call acceptance
// - master select rise starts, fall stops, arbitration loss clears silently
`timescale 1ns/1ps
module i2c_status_and_data_port (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);

   i2c_sdp_pkg::line_t sync1_ff, sync2_ff, sync3_ff, line_ff, prev_ff, nxt_line;
   i2c_sdp_pkg::ctrl_t ctrl_ff, nxt_ctrl;
   i2c_sdp_pkg::status_t stat_ff, nxt_stat;
   i2c_sdp_pkg::eng_t st_ff, nxt_st;
   i2c_sdp_pkg::gen_t gen_ff, nxt_gen;
   logic [6:0] own_ff, nxt_own;
   logic general_call_enable_ff, nxt_general_call_enable;
   logic [7:0] rx_data_ff, nxt_rx_data;
   logic [7:0] shift_ff, nxt_shift;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [i2c_sdp_pkg::TIMER_W-1:0] timer_ff, nxt_timer;
   logic sda_bit_ff, nxt_sda_bit;
   logic mclk_low_ff, nxt_mclk_low;
   logic is_addr_ff, nxt_is_addr;
   logic addressed_ff, nxt_addressed;
   logic xmit_ff, nxt_xmit;
   logic ack_low_ff, nxt_ack_low;
   logic scl_oe_ff, nxt_scl_oe;
   logic sda_oe_ff, nxt_sda_oe;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic wr_ctrl, wr_stat, wr_data, rd_data;
   logic ms_set_req, ms_clr_req, rsta_req, lose, done, can_go, match;

   // three-stage synchroniser; only the second stage reads the first
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync1_ff <= 2'h3;
         sync2_ff <= 2'h3;
         sync3_ff <= 2'h3;
         line_ff <= 2'h3;
         prev_ff <= 2'h3;
      end else begin
         sync1_ff <= {scl_i, sda_i};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         line_ff <= nxt_line;
         prev_ff <= line_ff;
      end
   end

   // a line change counts only once stages two and three agree
   always_comb begin
      nxt_line.scl = (sync2_ff.scl == sync3_ff.scl) ? sync3_ff.scl : line_ff.scl;
      nxt_line.sda = (sync2_ff.sda == sync3_ff.sda) ? sync3_ff.sda : line_ff.sda;
   end

   // bus event detection on the filtered lines
   assign scl_rise = line_ff.scl & ~prev_ff.scl;
   assign scl_fall = ~line_ff.scl & prev_ff.scl;
   assign start_det = line_ff.scl & prev_ff.scl & prev_ff.sda & ~line_ff.sda;
   assign stop_det = line_ff.scl & prev_ff.scl & ~prev_ff.sda & line_ff.sda;

   // register strobes
   assign wr_ctrl = reg_wr && (reg_addr == i2c_sdp_pkg::ADDR_CTRL);
   assign wr_stat = reg_wr && (reg_addr == i2c_sdp_pkg::ADDR_STAT);
   assign wr_data = reg_wr && (reg_addr == i2c_sdp_pkg::ADDR_DATA);
   assign rd_data = reg_rd && (reg_addr == i2c_sdp_pkg::ADDR_DATA);
   assign ms_set_req = wr_ctrl & reg_wdata[i2c_sdp_pkg::CTRL_MS_BIT] & ~ctrl_ff.ms & ctrl_ff.en;
   assign ms_clr_req = wr_ctrl & ~reg_wdata[i2c_sdp_pkg::CTRL_MS_BIT] & ctrl_ff.ms & ctrl_ff.en;
   assign rsta_req = wr_ctrl & reg_wdata[i2c_sdp_pkg::CTRL_RSTA_BIT] & ctrl_ff.en;
   assign done = (timer_ff == i2c_sdp_pkg::HALF_LAST);
   // slave accesses move bytes only once we have been addressed
   // slave needs match
   assign can_go = ctrl_ff.ms | addressed_ff;
   assign match = (shift_ff[7:1] == own_ff) | (general_call_enable_ff & (shift_ff[7:1] == i2c_sdp_pkg::GEN_CALL_ADDR));

   // next state of registers, flags, byte engine and condition generator
   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_stat = stat_ff;
      nxt_st = st_ff;
      nxt_gen = gen_ff;
      nxt_own = own_ff;
      nxt_general_call_enable = general_call_enable_ff;
      nxt_rx_data = rx_data_ff;
      nxt_shift = shift_ff;
      nxt_cnt = cnt_ff;
      nxt_timer = timer_ff;
      nxt_sda_bit = sda_bit_ff;
      nxt_mclk_low = mclk_low_ff;
      nxt_is_addr = is_addr_ff;
      nxt_addressed = addressed_ff;
      nxt_xmit = xmit_ff;
      nxt_ack_low = ack_low_ff;
      lose = 1'b0;

      // plain register writes
      if (reg_wr && (reg_addr == i2c_sdp_pkg::ADDR_OWN)) begin
         nxt_own = reg_wdata[6:0];
      end
      if (reg_wr && (reg_addr == i2c_sdp_pkg::ADDR_CTRL2)) begin
         nxt_general_call_enable = reg_wdata[i2c_sdp_pkg::CTRL2_GENERAL_CALL_ENABLE_BIT];
      end
      if (wr_ctrl) begin
         nxt_ctrl = reg_wdata;
         nxt_ctrl.ms = ctrl_ff.ms;
         nxt_ctrl.rsta = 1'b0;
         nxt_ctrl.rsvd = 2'h0;
         nxt_stat.aas = 1'b0;
      end
      // write-one-to-clear; the sets below override so no event is lost
      // al write one
      if (wr_stat) begin
         if (reg_wdata[i2c_sdp_pkg::STAT_AL_BIT]) begin
            nxt_stat.al = 1'b0;
         end
         if (reg_wdata[i2c_sdp_pkg::STAT_IF_BIT]) begin
            nxt_stat.iif = 1'b0;
         end
      end

      // master select and repeated start requests
      // start stop control
      if (ms_set_req) begin
         if (stat_ff.busy) begin
            lose = 1'b1;
         end else begin
            nxt_ctrl.ms = 1'b1;
            nxt_gen = i2c_sdp_pkg::GEN_START;
            nxt_timer = '0;
         end
      end else if (ms_clr_req) begin
         nxt_ctrl.ms = 1'b0;
         nxt_gen = i2c_sdp_pkg::GEN_STOP_A;
         nxt_timer = '0;
         nxt_st = i2c_sdp_pkg::ENG_IDLE;
      end else if (rsta_req) begin
         if (!ctrl_ff.ms) begin
            lose = 1'b1;
         end else if (st_ff == i2c_sdp_pkg::ENG_WAIT) begin
            nxt_gen = i2c_sdp_pkg::GEN_RS_A;
            nxt_timer = '0;
         end
      end

      // line condition generator; bit, GEN_STOP_B and GEN_RS_B high halves wait for the real line level
      case (gen_ff)
         i2c_sdp_pkg::GEN_NONE: begin
            if (ctrl_ff.ms && (st_ff == i2c_sdp_pkg::ENG_BITS || st_ff == i2c_sdp_pkg::ENG_ACK)) begin
               if (mclk_low_ff || line_ff.scl) begin
                  nxt_timer = done ? '0 : timer_ff + 1'b1;
                  if (done) begin
                     nxt_mclk_low = ~mclk_low_ff;
                  end
               end
            end
         end
         i2c_sdp_pkg::GEN_START, i2c_sdp_pkg::GEN_RS_C: begin
            nxt_timer = done ? '0 : timer_ff + 1'b1;
            if (done) begin
               nxt_gen = i2c_sdp_pkg::GEN_NONE;
            end
         end
         i2c_sdp_pkg::GEN_STOP_A, i2c_sdp_pkg::GEN_RS_A: begin
            nxt_timer = done ? '0 : timer_ff + 1'b1;
            if (done) begin
               nxt_gen = (gen_ff == i2c_sdp_pkg::GEN_STOP_A) ? i2c_sdp_pkg::GEN_STOP_B : i2c_sdp_pkg::GEN_RS_B;
            end
         end
         i2c_sdp_pkg::GEN_STOP_B, i2c_sdp_pkg::GEN_RS_B: begin
            if (line_ff.scl) begin
               nxt_timer = done ? '0 : timer_ff + 1'b1;
               if (done) begin
                  nxt_gen = (gen_ff == i2c_sdp_pkg::GEN_STOP_B) ? i2c_sdp_pkg::GEN_NONE : i2c_sdp_pkg::GEN_RS_C;
               end
            end
         end
         default: begin
            nxt_gen = i2c_sdp_pkg::GEN_NONE;
         end
      endcase

      // byte engine driven by filtered bus edges
      if (start_det) begin
         nxt_stat.busy = 1'b1;
         nxt_is_addr = 1'b1;
         nxt_addressed = 1'b0;
         nxt_cnt = 4'h0;
         nxt_xmit = 1'b0;
         nxt_sda_bit = 1'b1;
         nxt_st = ctrl_ff.ms ? i2c_sdp_pkg::ENG_WAIT : i2c_sdp_pkg::ENG_BITS;
         nxt_stat.transfer_complete_flag = ctrl_ff.ms;
      end else if (stop_det) begin
         nxt_stat.busy = 1'b0;
         nxt_st = i2c_sdp_pkg::ENG_IDLE;
         nxt_addressed = 1'b0;
         nxt_is_addr = 1'b0;
         nxt_xmit = 1'b0;
         if (ctrl_ff.ms) begin
            lose = 1'b1;
         end
      end else begin
         case (st_ff)
            i2c_sdp_pkg::ENG_BITS: begin
               if (scl_rise) begin
                  nxt_shift = {shift_ff[6:0], line_ff.sda};
                  nxt_cnt = cnt_ff + 4'h1;
                  if (ctrl_ff.ms && xmit_ff && sda_bit_ff && !line_ff.sda) begin
                     lose = 1'b1;
                  end
               end else if (scl_fall && cnt_ff == i2c_sdp_pkg::BYTE_BITS) begin
                  nxt_st = i2c_sdp_pkg::ENG_ACK;
                  nxt_sda_bit = 1'b1;
                  if (is_addr_ff && !ctrl_ff.ms) begin
                     // address always acked on match, regardless of txak
                     nxt_addressed = match;
                     nxt_ack_low = match;
                     if (match) begin
                        nxt_stat.slave_direction_flag = shift_ff[0];
                     end
                  end else begin
                     nxt_ack_low = ~xmit_ff & ~ctrl_ff.txak;
                  end
               end else if (scl_fall) begin
                  nxt_sda_bit = shift_ff[7];
               end
            end
            i2c_sdp_pkg::ENG_ACK: begin
               if (scl_rise) begin
                  nxt_stat.received_ack_flag = line_ff.sda;
                  if (ctrl_ff.ms && !xmit_ff && !ack_low_ff && !line_ff.sda) begin
                     lose = 1'b1;
                  end
               end else if (scl_fall) begin
                  nxt_ack_low = 1'b0;
                  nxt_is_addr = 1'b0;
                  if (!ctrl_ff.ms && !addressed_ff) begin
                     nxt_st = i2c_sdp_pkg::ENG_IDLE;
                  end else begin
                     nxt_st = i2c_sdp_pkg::ENG_WAIT;
                     nxt_stat.transfer_complete_flag = 1'b1;
                     nxt_stat.iif = 1'b1;
                     if (is_addr_ff && !ctrl_ff.ms) begin
                        nxt_stat.aas = 1'b1;
                     end
                     if (!xmit_ff && !is_addr_ff) begin
                        nxt_rx_data = shift_ff;
                     end
                  end
               end
            end
            i2c_sdp_pkg::ENG_WAIT: begin
               if (wr_data && can_go && ctrl_ff.tx && gen_ff == i2c_sdp_pkg::GEN_NONE) begin
                  nxt_st = i2c_sdp_pkg::ENG_BITS;
                  nxt_xmit = 1'b1;
                  nxt_shift = reg_wdata;
                  nxt_sda_bit = reg_wdata[7];
                  nxt_cnt = 4'h0;
                  nxt_stat.transfer_complete_flag = 1'b0;
                  nxt_mclk_low = 1'b1;
                  nxt_timer = '0;
               end else if (rd_data && can_go && !ctrl_ff.tx && gen_ff == i2c_sdp_pkg::GEN_NONE) begin
                  nxt_st = i2c_sdp_pkg::ENG_BITS;
                  nxt_xmit = 1'b0;
                  nxt_sda_bit = 1'b1;
                  nxt_cnt = 4'h0;
                  nxt_stat.transfer_complete_flag = 1'b0;
                  nxt_mclk_low = 1'b1;
                  nxt_timer = '0;
               end
            end
            default: begin
               nxt_st = i2c_sdp_pkg::ENG_IDLE;
            end
         endcase
      end

      // arbitration loss drops master without a stop and stops driving data
      // silent master clear
      if (lose) begin
         nxt_stat.al = 1'b1;
         nxt_stat.iif = 1'b1;
         nxt_ctrl.ms = 1'b0;
         nxt_xmit = 1'b0;
         nxt_sda_bit = 1'b1;
         nxt_gen = i2c_sdp_pkg::GEN_NONE;
      end

      nxt_stat.rsvd = 1'b0;

      if (!ctrl_ff.en) begin
         nxt_stat = '0;
         nxt_stat.transfer_complete_flag = i2c_sdp_pkg::TCF_RST;
         nxt_ctrl.ms = 1'b0;
         nxt_st = i2c_sdp_pkg::ENG_IDLE;
         nxt_gen = i2c_sdp_pkg::GEN_NONE;
         nxt_timer = '0;
         nxt_mclk_low = 1'b0;
         nxt_sda_bit = 1'b1;
         nxt_is_addr = 1'b0;
         nxt_addressed = 1'b0;
         nxt_xmit = 1'b0;
         nxt_ack_low = 1'b0;
      end

      // line drives; slave stretches the clock while software owes a byte
      case (gen_ff)
         i2c_sdp_pkg::GEN_START: begin
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b1;
         end
         i2c_sdp_pkg::GEN_STOP_A: begin
            nxt_scl_oe = 1'b1;
            nxt_sda_oe = 1'b1;
         end
         i2c_sdp_pkg::GEN_STOP_B, i2c_sdp_pkg::GEN_RS_C: begin
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b1;
         end
         i2c_sdp_pkg::GEN_RS_A: begin
            nxt_scl_oe = 1'b1;
            nxt_sda_oe = 1'b0;
         end
         i2c_sdp_pkg::GEN_RS_B: begin
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b0;
         end
         default: begin
            nxt_scl_oe = ((st_ff == i2c_sdp_pkg::ENG_WAIT) & can_go)
               | (ctrl_ff.ms & mclk_low_ff & ((st_ff == i2c_sdp_pkg::ENG_BITS) | (st_ff == i2c_sdp_pkg::ENG_ACK)));
            nxt_sda_oe = ((st_ff == i2c_sdp_pkg::ENG_BITS) & xmit_ff & ~sda_bit_ff)
               | ((st_ff == i2c_sdp_pkg::ENG_ACK) & ack_low_ff);
         end
      endcase
      if (!ctrl_ff.en) begin
         nxt_scl_oe = 1'b0;
         nxt_sda_oe = 1'b0;
      end

      // read data, valid only in the cycle after the read strobe
      nxt_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            i2c_sdp_pkg::ADDR_OWN: nxt_rdata = {1'b0, own_ff};
            i2c_sdp_pkg::ADDR_CTRL: nxt_rdata = ctrl_ff;
            i2c_sdp_pkg::ADDR_STAT: nxt_rdata = stat_ff;
            i2c_sdp_pkg::ADDR_DATA: nxt_rdata = rx_data_ff;
            i2c_sdp_pkg::ADDR_CTRL2: nxt_rdata = {general_call_enable_ff, 7'h00};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // state registers
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_ff <= i2c_sdp_pkg::CTRL_RST;
         stat_ff <= {i2c_sdp_pkg::TCF_RST, 7'h00};
         st_ff <= i2c_sdp_pkg::ENG_IDLE;
         gen_ff <= i2c_sdp_pkg::GEN_NONE;
         own_ff <= i2c_sdp_pkg::OWN_RST;
         general_call_enable_ff <= i2c_sdp_pkg::GENERAL_CALL_ENABLE_RST;
         rx_data_ff <= i2c_sdp_pkg::DATA_RST;
         shift_ff <= 8'h00;
         rdata_ff <= 8'h00;
         cnt_ff <= 4'h0;
         timer_ff <= '0;
         sda_bit_ff <= 1'b1;
         mclk_low_ff <= 1'b0;
         is_addr_ff <= 1'b0;
         addressed_ff <= 1'b0;
         xmit_ff <= 1'b0;
         ack_low_ff <= 1'b0;
         scl_oe_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         stat_ff <= nxt_stat;
         st_ff <= nxt_st;
         gen_ff <= nxt_gen;
         own_ff <= nxt_own;
         general_call_enable_ff <= nxt_general_call_enable;
         rx_data_ff <= nxt_rx_data;
         shift_ff <= nxt_shift;
         rdata_ff <= nxt_rdata;
         cnt_ff <= nxt_cnt;
         timer_ff <= nxt_timer;
         sda_bit_ff <= nxt_sda_bit;
         mclk_low_ff <= nxt_mclk_low;
         is_addr_ff <= nxt_is_addr;
         addressed_ff <= nxt_addressed;
         xmit_ff <= nxt_xmit;
         ack_low_ff <= nxt_ack_low;
         scl_oe_ff <= nxt_scl_oe;
         sda_oe_ff <= nxt_sda_oe;
      end
   end

   // outputs; open-drain pins only ever pull low
   assign reg_rdata = rdata_ff;
   assign irq = stat_ff.iif & ctrl_ff.ie;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = scl_oe_ff;
   assign sda_oe = sda_oe_ff;

endmodule // i2c_status_and_data_port

// File: i2c_sdp_pkg.sv
// constants, field layouts and state encodings for the two-wire status and data port
package i2c_sdp_pkg;

   // register offsets on the plain register port
   localparam logic [2:0] ADDR_OWN = 3'h0;
   localparam logic [2:0] ADDR_CTRL = 3'h1;
   localparam logic [2:0] ADDR_STAT = 3'h2;
   localparam logic [2:0] ADDR_DATA = 3'h3;
   localparam logic [2:0] ADDR_CTRL2 = 3'h4;

   // field positions used for write decoding
   localparam int CTRL_MS_BIT = 5;
   localparam int CTRL_RSTA_BIT = 2;
   localparam int STAT_AL_BIT = 4;
   localparam int STAT_IF_BIT = 1;
   localparam int CTRL2_GENERAL_CALL_ENABLE_BIT = 7;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [6:0] OWN_RST = 7'h00;
   localparam logic GENERAL_CALL_ENABLE_RST = 1'b0;
   localparam logic TCF_RST = 1'b1;
   localparam logic [7:0] DATA_RST = 8'h00;

   // general call address and byte length
   localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // timing: half period of the generated serial clock
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_HALF_NS = 5000;
   localparam int HALF_CYC = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 10;
   localparam logic [TIMER_W-1:0] HALF_LAST = TIMER_W'(HALF_CYC - 1);

   // control register layout
   typedef struct packed {
      logic en;
      logic ie;
      logic ms;
      logic tx;
      logic txak;
      logic rsta;
      logic [1:0] rsvd;
   } ctrl_t;

   // status register layout
   typedef struct packed {
      logic transfer_complete_flag;
      logic aas;
      logic busy;
      logic al;
      logic rsvd;
      logic slave_direction_flag;
      logic iif;
      logic received_ack_flag;
   } status_t;

   // serial line pair, clock high bit
   typedef struct packed {
      logic scl;
      logic sda;
   } line_t;

   // byte engine, gray along idle, bits, ack, wait
   typedef enum logic [1:0] {
      ENG_IDLE = 2'h0,
      ENG_BITS = 2'h1,
      ENG_ACK = 2'h3,
      ENG_WAIT = 2'h2
   } eng_t;

   // master line condition generator
   typedef enum logic [2:0] {
      GEN_NONE = 3'h0,
      GEN_START = 3'h1,
      GEN_STOP_A = 3'h3,
      GEN_STOP_B = 3'h2,
      GEN_RS_A = 3'h6,
      GEN_RS_B = 3'h7,
      GEN_RS_C = 3'h5
   } gen_t;

endpackage

// File: i2c_sdp_checker.sv
// pin-level checks for the two-wire status and data port
`timescale 1ns/1ps
module i2c_sdp_checker (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic irq,
   input wire logic scl_oe,
   input wire logic sda_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   logic [7:0] ctrl_ff;
   logic [7:0] nxt_ctrl;
   // shadow of the control register, so gating can be judged from the pins
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (reg_wr && reg_addr == i2c_sdp_pkg::ADDR_CTRL) begin
         nxt_ctrl = reg_wdata;
      end
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl_ff <= 8'h00;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end
   sequence s_stat_read;
      $past(reg_rd) && $past(reg_addr) == i2c_sdp_pkg::ADDR_STAT;
   endsequence
   sequence s_start;
      $rose(sda_oe) && !scl_oe;
   endsequence
   // two cycles of margin: pins and flags settle one edge after the write
   sequence s_off;
      !ctrl_ff[7] && !$past(ctrl_ff[7]) && !$past(ctrl_ff[7], 2);
   endsequence
   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == 8'h00;
   endproperty
   property p_rsvd_zero;
      s_stat_read |-> !reg_rdata[3];
   endproperty
   property p_irq_gate;
      irq |-> ctrl_ff[6];
   endproperty
   property p_irq_follow;
      s_stat_read |-> $past(irq) == (reg_rdata[1] && $past(ctrl_ff[6]));
   endproperty
   property p_dis_status;
      (s_stat_read and s_off) |-> reg_rdata == 8'h80;
   endproperty
   property p_dis_pins;
      s_off |-> !sda_oe && !scl_oe;
   endproperty
   property p_scl_hold;
      $rose(scl_oe) |-> scl_oe[*8];
   endproperty
   property p_start;
      s_start |=> !scl_oe[*8];
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bit set");
   a_irq_gate: assert property (p_irq_gate) else $error("request raised with enable clear");
   a_irq_follow: assert property (p_irq_follow) else $error("request does not follow flag");
   a_dis_status: assert property (p_dis_status) else $error("status not idle while disabled");
   a_dis_pins: assert property (p_dis_pins) else $error("pins driven while disabled");
   a_scl_hold: assert property (p_scl_hold) else $error("clock low phase too short");
   a_start: assert property (p_start) else $error("clock pulled too soon after start");
endmodule // i2c_sdp_checker

bind i2c_status_and_data_port i2c_sdp_checker i2c_sdp_checker_i (.core_clk(core_clk), .reset(reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .irq(irq), .scl_oe(scl_oe), .sda_oe(sda_oe));

// File: i2c_bus_partner.sv
// behavioural slave on the shared bus: acks bytes, can hold data low
`timescale 1ns/1ps
module i2c_bus_partner (
   input wire logic scl,
   input wire logic sda,
   input wire logic ack_en,
   input wire logic fight,
   output logic sda_pull,
   output logic [7:0] last_byte
);
   int cnt = 0;
   logic [7:0] sh = 8'h00;
   logic ack = 1'b0;
   initial last_byte = 8'h00;
   // start condition restarts the bit count
   always @(negedge sda) begin
      if (scl) begin
         cnt = 0;
      end
   end
   // bits taken on the clock rise, msb first
   always @(posedge scl) begin
      if (cnt < 8) begin
         sh = {sh[6:0], sda};
      end
      cnt = cnt + 1;
      if (cnt == 8) begin
         last_byte = sh;
      end
   end
   // late ack move: data must not change while the device still sees clock high
   always @(negedge scl) begin
      #200;
      if (cnt == 8) begin
         ack = ack_en;
      end else if (cnt == 9) begin
         ack = 1'b0;
         cnt = 0;
      end
   end
   assign sda_pull = ack | fight;
endmodule // i2c_bus_partner

// File: tb.sv
// self-checking bench for the two-wire status and data port
`timescale 1ns/1ps
module tb;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ack_en = 1'b1;
   logic fight = 1'b0;
   logic [7:0] reg_rdata, got, v;
   logic irq, scl_oe, sda_oe, sda_pull, scl_o, sda_o;
   // a second master on the wires, high pulls the line low
   logic ext_scl = 1'b0;
   logic ext_sda = 1'b0;
   int bad_count = 0;
   int checked = 0;
   // open-drain wires with pull-ups
   wire scl_w = ~(scl_oe | ext_scl);
   wire sda_w = ~(sda_oe | sda_pull | ext_sda);
   always #5 core_clk = ~core_clk;
   i2c_status_and_data_port i2c_status_and_data_port_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
   i2c_bus_partner i2c_bus_partner_i (.scl(scl_w), .sda(sda_w), .ack_en(ack_en), .fight(fight),
      .sda_pull(sda_pull), .last_byte(got));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // an idle cycle follows each strobe so no signal is assigned twice at one edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask
   // a byte takes about nine thousand cycles; the bound leaves slack
   task automatic wait_irq();
      for (int n = 0; n < 30000 && irq !== 1'b1; n++) begin
         @(posedge core_clk);
      end
      chk({7'h00, irq}, 8'h01);
   endtask
   task automatic t_idle();
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v, 8'h80);
      rd(3'h7, v);
      chk(v, 8'h00);
      wr(i2c_sdp_pkg::ADDR_DATA, 8'ha4);
      repeat (100) @(posedge core_clk);
      chk({4'h0, scl_o, sda_o, sda_oe, scl_oe}, 8'h00);
   endtask
   // enable first: the other control bits do nothing while disabled
   task automatic t_master_write();
      wr(i2c_sdp_pkg::ADDR_CTRL, 8'hd0);
      wr(i2c_sdp_pkg::ADDR_CTRL, 8'hf0);
      repeat (600) @(posedge core_clk);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v & 8'h20, 8'h20);
      wr(i2c_sdp_pkg::ADDR_DATA, 8'ha4);
      wait_irq();
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v, 8'ha2);
      chk(got, 8'ha4);
      wr(i2c_sdp_pkg::ADDR_STAT, 8'h00);
      chk({7'h00, irq}, 8'h01);
      wr(i2c_sdp_pkg::ADDR_CTRL, 8'hb0);
      chk({7'h00, irq}, 8'h00);
      wr(i2c_sdp_pkg::ADDR_CTRL, 8'hf0);
      chk({7'h00, irq}, 8'h01);
      wr(i2c_sdp_pkg::ADDR_STAT, 8'hff);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v, 8'ha0);
   endtask
   task automatic t_nack();
      ack_en <= 1'b0;
      wr(i2c_sdp_pkg::ADDR_DATA, 8'h3c);
      wait_irq();
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v, 8'ha3);
      chk(got, 8'h3c);
      rd(i2c_sdp_pkg::ADDR_DATA, v);
      chk(v, i2c_sdp_pkg::DATA_RST);
      wr(i2c_sdp_pkg::ADDR_STAT, 8'h02);
      ack_en <= 1'b1;
   endtask
   task automatic t_arb();
      fight <= 1'b1;
      wr(i2c_sdp_pkg::ADDR_DATA, 8'hff);
      wait_irq();
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v & 8'h16, 8'h12);
      rd(i2c_sdp_pkg::ADDR_CTRL, v);
      chk(v & 8'h20, 8'h00);
      wr(i2c_sdp_pkg::ADDR_STAT, 8'h00);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v & 8'h10, 8'h10);
      wr(i2c_sdp_pkg::ADDR_STAT, 8'h12);
      wr(i2c_sdp_pkg::ADDR_CTRL, 8'hf0);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v & 8'h32, 8'h32);
      wr(i2c_sdp_pkg::ADDR_STAT, 8'h12);
      fight <= 1'b0;
      repeat (200) @(posedge core_clk);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v & 8'h20, 8'h00);
   endtask
   // another master calls address 35h for a read; the ack clock ends the byte
   task automatic t_slave();
      logic [8:0] b = 9'h0d7;
      ack_en <= 1'b0;
      wr(i2c_sdp_pkg::ADDR_OWN, 8'h35);
      ext_sda <= 1'b1;
      for (int i = 8; i >= 0; i--) begin
         repeat (20) @(posedge core_clk);
         ext_scl <= 1'b1;
         repeat (10) @(posedge core_clk);
         ext_sda <= ~b[i];
         repeat (10) @(posedge core_clk);
         ext_scl <= 1'b0;
      end
      repeat (20) @(posedge core_clk);
      ext_scl <= 1'b1;
      wait_irq();
      repeat (10) @(posedge core_clk);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v, 8'he6);
      wr(i2c_sdp_pkg::ADDR_CTRL, {3'h6, v[2], 4'h0});
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v, 8'ha6);
      wr(i2c_sdp_pkg::ADDR_DATA, 8'h5a);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v & 8'h80, 8'h00);
   endtask
   task automatic final_report();
      if (bad_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      t_idle();
      t_master_write();
      t_nack();
      t_arb();
      t_slave();
      wr(i2c_sdp_pkg::ADDR_CTRL, 8'h00);
      rd(i2c_sdp_pkg::ADDR_STAT, v);
      chk(v, 8'h80);
      final_report();
   end
   // the run needs well under half a millisecond
   initial begin
      #500000;
      bad_count++;
      final_report();
   end
endmodule // tb
